// >>> core/sri_defs.svh
// Offsets, field positions, reset values and timing counts of the supervision block
`ifndef SRI_DEFS_SVH
`define SRI_DEFS_SVH
`define SRI_OFS_RT       8'h00
`define SRI_OFS_RT_CLR   8'h04
`define SRI_OFS_MASK     8'h08
`define SRI_OFS_CFG      8'h0C
`define SRI_OFS_DEB      8'h10
`define SRI_OFS_GK       8'h14
`define SRI_OFS_CHEN     8'h18
`define SRI_OFS_CMD      8'h1C
`define SRI_OFS_STAT     8'h20
`define SRI_OFS_ATI      8'h24
`define SRI_OFS_PCM      8'h28
`define SRI_CMD_ACT      0
`define SRI_CMD_DEACT    1
`define SRI_CMD_SWRST    2
`define SRI_CMD_HWRST    3
`define SRI_RST_MASK     8'hFF
`define SRI_RST_DEB      4'h8
`define SRI_RST_CHEN     4'hF
`define SRI_RST_PCM      32'h0000_3210
`define SRI_GK_MAX       3'd6
`define SRI_FS_PER_MS    4'd8
`define SRI_CS_RST_EDGES 5'd16
`define SRI_CLK_HZ       40000000
`define SRI_CHOP0_HZ     256000
`define SRI_CHOP1_HZ     292570
`define SRI_CHOP0_HALF   (`SRI_CLK_HZ / (2 * `SRI_CHOP0_HZ))
`define SRI_CHOP1_HALF   (`SRI_CLK_HZ / (2 * `SRI_CHOP1_HZ))
`define SRI_RESP_OKAY    2'b00
`define SRI_RESP_SLVERR  2'b10
`endif

// >>> core/sri_pkg.sv
// Types shared by the supervision and interrupt block
package sri_pkg;
  typedef struct packed {
    logic       mu_law;      // 0 selects A-law
    logic       mux_pol_low; // 0 gives high-going mux pulses
    logic       mux_enable;  // Detector multiplexing on
    logic       chopper_enable;
    logic       chopper_freq_select;
    logic       interrupt_output_type; // 1 totem-pole, 0 open-drain
  } sri_cfg_s;

  typedef enum logic [0:0] {
    SRI_B_IDLE = 1'b0,
    SRI_B_RESP = 1'b1
  } sri_bus_e;
endpackage

// >>> core/sri_top.sv
// Supervision real-time data register, interrupt, channel state and chopper clock
//
// Overview of operation
// - one 8-bit register, two bits per channel
// - primary bit is debounced loop detect
// - secondary bit: second detect or muxed ground key
// - filters advance only on frame sync, except ground key with period 0
// - real-time register readable at any time
// - real-time data copied to upstream SC field
// - unmasked supervision change pulls interrupt low
// - armed channel transmit change raises interrupt
// - interrupt holds until a clearing event
// - output type bit picks totem-pole or open-drain
// - unmasked bits freeze while interrupt pending
// - cleared by clearing read, mask write, reset
// - clearing read with pending difference re-asserts
// - read/write mask, one bit per status bit
// - activate command sets enabled channels active
// - resets and deactivate make channels inactive
// - chopper 256 or 292.57 kHz, runs when enabled
// - reset by pin, command, long chip select
// - reset clears, masks, open-drain, 8 ms debounce
// - reset gives default slots, port A, clock
// - reset gives A-law, inputs, chopper off
// - debounce restarts on change, counts ms ticks
// - ground-key saturating counter 0 to 6
//
// Decided for this implementation: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "sri_defs.svh"
module sri_top
  import sri_pkg::*;
#(
  parameter int NCH = 4
)(
  input  wire logic             core_clk_in,
  input  wire logic             rst_in,
  input  wire logic             s_axi_awvalid_in,
  output logic                  s_axi_awready_out,
  input  wire logic [7:0]       s_axi_awaddr_in,
  input  wire logic             s_axi_wvalid_in,
  output logic                  s_axi_wready_out,
  input  wire logic [31:0]      s_axi_wdata_in,
  input  wire logic [3:0]       s_axi_wstrb_in,
  output logic                  s_axi_bvalid_out,
  input  wire logic             s_axi_bready_in,
  output logic [1:0]            s_axi_bresp_out,
  input  wire logic             s_axi_arvalid_in,
  output logic                  s_axi_arready_out,
  input  wire logic [7:0]       s_axi_araddr_in,
  output logic                  s_axi_rvalid_out,
  input  wire logic             s_axi_rready_in,
  output logic [31:0]           s_axi_rdata_out,
  output logic [1:0]            s_axi_rresp_out,
  input  wire logic             frame_sync_in,
  input  wire logic [NCH-1:0]   loop_detect_input_in,
  input  wire logic [NCH-1:0]   second_detect_input_in,
  input  wire logic [NCH-1:0]   muxed_ground_key_bit_in,
  input  wire logic [NCH-1:0]   tx_pcm_change_in,
  input  wire logic             reset_pin_n_in,
  input  wire logic             chip_select_n_in,
  input  wire logic             serial_data_clock_in,
  output logic                  int_n_out,
  output logic                  int_n_oe_out,
  output logic                  chopper_clk_out,
  output logic [2*NCH-1:0]      sc_upstream_rt_out,
  output logic [NCH-1:0]        channel_state_flag_out
);

  // Two-stage synchronisers for every pin input except tx_pcm_change_in
  logic [3*NCH+3:0] pin_s1_r;
  logic [3*NCH+3:0] pin_s2_r;
  always_ff @(posedge core_clk_in)
  begin
    pin_s1_r <= {frame_sync_in, reset_pin_n_in, chip_select_n_in, serial_data_clock_in,
                 muxed_ground_key_bit_in, second_detect_input_in, loop_detect_input_in};
    pin_s2_r <= pin_s1_r;
  end

  logic [NCH-1:0] ld_s;
  logic [NCH-1:0] cd2_s;
  logic [NCH-1:0] gkm_s;
  logic           fs_s;
  logic           rstn_s;
  logic           csn_s;
  logic           serial_data_clock_s;
  assign ld_s   = pin_s2_r[NCH-1:0];
  assign cd2_s  = pin_s2_r[2*NCH-1:NCH];
  assign gkm_s  = pin_s2_r[3*NCH-1:2*NCH];
  assign serial_data_clock_s = pin_s2_r[3*NCH];
  assign csn_s  = pin_s2_r[3*NCH+1];
  assign rstn_s = pin_s2_r[3*NCH+2];
  assign fs_s   = pin_s2_r[3*NCH+3];

  // Edge history of synchronised frame sync and data clock
  logic fs_d_r;
  logic serial_data_clock_d_r;
  always_ff @(posedge core_clk_in)
  begin
    fs_d_r   <= fs_s;
    serial_data_clock_d_r <= serial_data_clock_s;
  end

  logic fs_tick;
  assign fs_tick = fs_s & ~fs_d_r;

  // Chip select held low over 16 rising data clock edges forces a reset
  logic [4:0] cs_cnt_r;
  logic       cs_rst;
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in || csn_s)
      cs_cnt_r <= 5'd0;
    else if (serial_data_clock_s && !serial_data_clock_d_r && cs_cnt_r != `SRI_CS_RST_EDGES)
      cs_cnt_r <= cs_cnt_r + 5'd1;
  end
  assign cs_rst = (cs_cnt_r == `SRI_CS_RST_EDGES);

  // Any reset source resets the device state; bus handshake keeps rst_in only
  logic hw_cmd_r;
  logic dev_rst;
  assign dev_rst = rst_in | ~rstn_s | cs_rst | hw_cmd_r;

  // Software registers
  sri_cfg_s        cfg_r;
  logic [2*NCH-1:0] mask_r;
  logic [3:0]      deb_r;
  logic [4*NCH-1:0] gk_r;
  logic [NCH-1:0]  chen_r;
  logic [NCH-1:0]  ati_r;
  logic [31:0]     pcm_r;
  logic [NCH-1:0]  channel_state_flag_r;

  // Write channel: address and data taken in either order
  sri_bus_e   wst_r;
  logic       aw_have_r;
  logic       w_have_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic       wr_go;
  logic       wr_hit;
  assign s_axi_awready_out = (wst_r == SRI_B_IDLE) && !aw_have_r;
  assign s_axi_wready_out  = (wst_r == SRI_B_IDLE) && !w_have_r;
  assign wr_go = (wst_r == SRI_B_IDLE) && aw_have_r && w_have_r;

  function automatic logic map_hit(input logic [7:0] a, input logic wr);
    unique case (a)
      `SRI_OFS_RT, `SRI_OFS_RT_CLR, `SRI_OFS_STAT: map_hit = !wr;
      `SRI_OFS_MASK, `SRI_OFS_CFG, `SRI_OFS_DEB, `SRI_OFS_GK,
      `SRI_OFS_CHEN, `SRI_OFS_ATI, `SRI_OFS_PCM:   map_hit = 1'b1;
      `SRI_OFS_CMD:                                map_hit = wr;
      default:                                     map_hit = 1'b0;
    endcase
  endfunction
  assign wr_hit = map_hit(awaddr_r, 1'b1);

  // Write handshake state
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      wst_r           <= SRI_B_IDLE;
      aw_have_r       <= 1'b0;
      w_have_r        <= 1'b0;
      awaddr_r        <= 8'h00;
      wdata_r         <= 32'h0000_0000;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= `SRI_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid_in && s_axi_awready_out)
      begin
        aw_have_r <= 1'b1;
        awaddr_r  <= {s_axi_awaddr_in[7:2], 2'b00};
      end
      if (s_axi_wvalid_in && s_axi_wready_out)
      begin
        w_have_r <= 1'b1;
        wdata_r  <= s_axi_wdata_in;
      end
      if (wr_go)
      begin
        wst_r            <= SRI_B_RESP;
        aw_have_r        <= 1'b0;
        w_have_r         <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out  <= wr_hit ? `SRI_RESP_OKAY : `SRI_RESP_SLVERR;
      end
      else if (wst_r == SRI_B_RESP && s_axi_bready_in)
      begin
        wst_r            <= SRI_B_IDLE;
        s_axi_bvalid_out <= 1'b0;
      end
    end
  end

  // Register stores; strobes are ignored for every field, the 32-bit PCM word included
  logic wr_mask;
  logic wr_cmd;
  assign wr_mask = wr_go && awaddr_r == `SRI_OFS_MASK;
  assign wr_cmd  = wr_go && awaddr_r == `SRI_OFS_CMD;
  always_ff @(posedge core_clk_in)
  begin
    if (dev_rst)
    begin
      cfg_r  <= '0;
      mask_r <= `SRI_RST_MASK;
      deb_r  <= `SRI_RST_DEB;
      gk_r   <= '0;
      chen_r <= `SRI_RST_CHEN;
      ati_r  <= '0;
      pcm_r  <= `SRI_RST_PCM;
    end
    else if (wr_go)
    begin
      unique case (awaddr_r)
        `SRI_OFS_MASK: mask_r <= wdata_r[2*NCH-1:0];
        `SRI_OFS_CFG:  cfg_r  <= wdata_r[5:0];
        `SRI_OFS_DEB:  deb_r  <= wdata_r[3:0];
        `SRI_OFS_GK:   gk_r   <= wdata_r[4*NCH-1:0];
        `SRI_OFS_CHEN: chen_r <= wdata_r[NCH-1:0];
        `SRI_OFS_ATI:  ati_r  <= wdata_r[NCH-1:0];
        `SRI_OFS_PCM:  pcm_r  <= wdata_r;
        default:       ;
      endcase
    end
  end

  // Hardware reset command lasts one cycle and resets itself
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
      hw_cmd_r <= 1'b0;
    else
      hw_cmd_r <= wr_cmd && wdata_r[`SRI_CMD_HWRST] && !hw_cmd_r;
  end

  // Channel state: only the activate command can set a flag
  always_ff @(posedge core_clk_in)
  begin
    if (dev_rst)
      channel_state_flag_r <= '0;
    else if (wr_cmd && wdata_r[`SRI_CMD_ACT])
      channel_state_flag_r <= channel_state_flag_r | chen_r;
    else if (wr_cmd && (wdata_r[`SRI_CMD_DEACT] || wdata_r[`SRI_CMD_SWRST]))
      channel_state_flag_r <= channel_state_flag_r & ~chen_r;
  end
  assign channel_state_flag_out = channel_state_flag_r;

  // One millisecond tick from eight frame syncs
  logic [3:0] fs_cnt_r;
  logic       ms_tick;
  always_ff @(posedge core_clk_in)
  begin
    if (dev_rst)
      fs_cnt_r <= 4'd0;
    else if (fs_tick)
      fs_cnt_r <= (fs_cnt_r == `SRI_FS_PER_MS - 4'd1) ? 4'd0 : fs_cnt_r + 4'd1;
  end
  assign ms_tick = fs_tick && (fs_cnt_r == `SRI_FS_PER_MS - 4'd1);

  // Per-channel loop-detect debounce and ground-key filter
  logic [NCH-1:0] cda_r;
  logic [NCH-1:0] cdb_r;
  logic [NCH-1:0] ld_smp_r;
  logic [3:0]     deb_cnt_r [NCH];
  logic [2:0]     gk_cnt_r  [NCH];
  logic [3:0]     gk_tmr_r  [NCH];
  logic [NCH-1:0] gk_in;
  assign gk_in = cfg_r.mux_enable ? gkm_s : cd2_s;

  for (genvar c = 0; c < NCH; c++)
  begin : g_ch
    logic [3:0] gper;
    assign gper = gk_r[4*c+3:4*c];

    // Any change at frame rate restarts the count
    always_ff @(posedge core_clk_in)
    begin
      if (dev_rst)
      begin
        ld_smp_r[c]  <= 1'b0;
        deb_cnt_r[c] <= 4'd0;
        cda_r[c]     <= 1'b0;
      end
      else if (fs_tick)
      begin
        ld_smp_r[c] <= ld_s[c];
        if (ld_s[c] != ld_smp_r[c])
          deb_cnt_r[c] <= 4'd0;
        else if (deb_cnt_r[c] >= deb_r)
          cda_r[c] <= ld_smp_r[c];
        else if (ms_tick)
          deb_cnt_r[c] <= deb_cnt_r[c] + 4'd1;
      end
    end

    // Saturating duty-cycle counter sampled every programmed period
    always_ff @(posedge core_clk_in)
    begin
      if (dev_rst)
      begin
        gk_tmr_r[c] <= 4'd0;
        gk_cnt_r[c] <= 3'd0;
        cdb_r[c]    <= 1'b0;
      end
      else if (gper == 4'd0)
        cdb_r[c] <= gk_in[c];
      else if (ms_tick)
      begin
        if (gk_tmr_r[c] + 4'd1 >= gper)
        begin
          gk_tmr_r[c] <= 4'd0;
          if (gk_in[c] && gk_cnt_r[c] != `SRI_GK_MAX)
            gk_cnt_r[c] <= gk_cnt_r[c] + 3'd1;
          else if (!gk_in[c] && gk_cnt_r[c] != 3'd0)
            gk_cnt_r[c] <= gk_cnt_r[c] - 3'd1;
          if (gk_in[c] && gk_cnt_r[c] >= `SRI_GK_MAX - 3'd1)
            cdb_r[c] <= 1'b1;
          else if (!gk_in[c] && gk_cnt_r[c] <= 3'd1)
            cdb_r[c] <= 1'b0;
        end
        else
          gk_tmr_r[c] <= gk_tmr_r[c] + 4'd1;
      end
    end
  end

  // Live supervision word, channel pairs secondary above primary
  logic [2*NCH-1:0] rt_live;
  always_comb
  begin
    for (int c = 0; c < NCH; c++)
    begin
      rt_live[2*c]   = cda_r[c];
      rt_live[2*c+1] = cdb_r[c];
    end
  end

  // Latched real-time register and pending interrupt
  logic [2*NCH-1:0] rt_r;
  logic             pend_r;
  logic             rd_clr;
  logic [2*NCH-1:0] diff;
  logic             tx_ev;
  assign diff  = (rt_live ^ rt_r) & ~mask_r;
  assign tx_ev = |(tx_pcm_change_in & ati_r);

  // Events in a clearing cycle win over the clear so nothing is lost
  always_ff @(posedge core_clk_in)
  begin
    if (dev_rst)
    begin
      rt_r   <= '0;
      pend_r <= 1'b0;
    end
    else if (!pend_r || rd_clr || wr_mask)
    begin
      rt_r   <= rt_live;
      pend_r <= (|diff) || tx_ev;
    end
    else
    begin
      rt_r   <= (rt_r & ~mask_r) | (rt_live & mask_r);
      pend_r <= 1'b1;
    end
  end
  assign sc_upstream_rt_out = rt_r;

  // Interrupt pin: open-drain floats when idle, totem-pole drives high
  assign int_n_out    = ~pend_r & cfg_r.interrupt_output_type;
  assign int_n_oe_out = pend_r | cfg_r.interrupt_output_type;

  // Read channel, one cycle from address to data
  logic [31:0] rd_val;
  always_comb
  begin
    rd_val = 32'h0000_0000;
    unique case (s_axi_araddr_in & 8'hFC)
      `SRI_OFS_RT, `SRI_OFS_RT_CLR: rd_val[2*NCH-1:0] = rt_r;
      `SRI_OFS_MASK: rd_val[2*NCH-1:0] = mask_r;
      `SRI_OFS_CFG:  rd_val[5:0] = cfg_r;
      `SRI_OFS_DEB:  rd_val[3:0] = deb_r;
      `SRI_OFS_GK:   rd_val[4*NCH-1:0] = gk_r;
      `SRI_OFS_CHEN: rd_val[NCH-1:0] = chen_r;
      `SRI_OFS_ATI:  rd_val[NCH-1:0] = ati_r;
      `SRI_OFS_PCM:  rd_val = pcm_r;
      `SRI_OFS_STAT: rd_val[NCH:0] = {pend_r, channel_state_flag_r};
      default:       rd_val = 32'h0000_0000;
    endcase
  end

  assign s_axi_arready_out = !s_axi_rvalid_out;
  assign rd_clr = s_axi_arvalid_in && s_axi_arready_out
               && (s_axi_araddr_in & 8'hFC) == `SRI_OFS_RT_CLR;

  // Read data is registered; taking the address clears for the clearing view
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out  <= 32'h0000_0000;
      s_axi_rresp_out  <= `SRI_RESP_OKAY;
    end
    else if (s_axi_arvalid_in && s_axi_arready_out)
    begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out  <= rd_val;
      s_axi_rresp_out  <= map_hit(s_axi_araddr_in & 8'hFC, 1'b0) ?
                          `SRI_RESP_OKAY : `SRI_RESP_SLVERR;
    end
    else if (s_axi_rready_in)
      s_axi_rvalid_out <= 1'b0;
  end

  // Chopper divider; integer half periods so frequencies are approximate
  localparam logic [7:0] CH_H0 = 8'(`SRI_CHOP0_HALF);
  localparam logic [7:0] CH_H1 = 8'(`SRI_CHOP1_HALF);
  logic [7:0] chop_cnt_r;
  logic [7:0] chop_half;
  assign chop_half = cfg_r.chopper_freq_select ? CH_H1 : CH_H0;
  always_ff @(posedge core_clk_in)
  begin
    if (dev_rst || !cfg_r.chopper_enable)
    begin
      chop_cnt_r      <= 8'd0;
      chopper_clk_out <= 1'b0;
    end
    else if (chop_cnt_r + 8'd1 >= chop_half)
    begin
      chop_cnt_r      <= 8'd0;
      chopper_clk_out <= ~chopper_clk_out;
    end
    else
      chop_cnt_r <= chop_cnt_r + 8'd1;
  end

endmodule

// >>> bench/sri_host_model.sv
// Host-side model: free-running frame sync and the pulled-up interrupt line
`timescale 1ns/1ps
module sri_host_model #(
  parameter int FS_PER = 16
)(
  input  wire logic clk_in,
  input  wire logic int_n_in,
  input  wire logic int_oe_in,
  output logic      frame_sync_out,
  output logic      irq_level_out
);
  logic [7:0] fs_cnt_r = 8'h00;

  // Frame counter; the short frame keeps zero-debounce filter delays to a few dozen cycles
  always_ff @(posedge clk_in)
  begin
    fs_cnt_r <= (fs_cnt_r == 8'(FS_PER - 1)) ? 8'h00 : fs_cnt_r + 8'h01;
  end

  // Frame sync is always supplied, else no filter except ground key with period 0 advances
  assign frame_sync_out = (fs_cnt_r < 8'h02);
  // Released line reads high through the pull-up; sensed as a level
  assign irq_level_out  = int_oe_in ? !int_n_in : 1'b0;
endmodule

// >>> bench/sri_top_sva.sv
// Port-level checks of the supervision and interrupt block
`timescale 1ns/1ps
`include "sri_defs.svh"
module sri_top_sva #(
  parameter int NCH = 4
)(
  input wire logic             core_clk_in,
  input wire logic             rst_in,
  input wire logic             s_axi_arvalid_in,
  input wire logic             s_axi_arready_out,
  input wire logic [7:0]       s_axi_araddr_in,
  input wire logic             s_axi_rvalid_out,
  input wire logic [31:0]      s_axi_rdata_out,
  input wire logic [1:0]       s_axi_rresp_out,
  input wire logic             s_axi_bvalid_out,
  input wire logic             reset_pin_n_in,
  input wire logic             chip_select_n_in,
  input wire logic             int_n_out,
  input wire logic             int_n_oe_out,
  input wire logic             chopper_clk_out,
  input wire logic [2*NCH-1:0] sc_upstream_rt_out,
  input wire logic [NCH-1:0]   channel_state_flag_out
);
  logic [6:0] hi_cnt_r;
  logic [3:0] pin_hist_r = 4'hF;
  logic       irq;
  logic       clr_rd;
  logic       ext_rst;

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);

  // Asserted in either output mode means driven and low
  assign irq     = int_n_oe_out && !int_n_out;
  assign clr_rd  = s_axi_arvalid_in && s_axi_arready_out
                   && (s_axi_araddr_in == `SRI_OFS_RT_CLR);
  // Pin resets land late through the synchronisers, so look back four cycles
  assign ext_rst = !reset_pin_n_in || (pin_hist_r != 4'hF) || !chip_select_n_in;

  // Reset pin history and length of the current chopper high half
  always_ff @(posedge core_clk_in)
  begin
    pin_hist_r <= {pin_hist_r[2:0], reset_pin_n_in};
    hi_cnt_r   <= chopper_clk_out ? hi_cnt_r + 7'd1 : 7'd0;
  end

  sequence rd_take;
    s_axi_arvalid_in && s_axi_arready_out;
  endsequence
  sequence held_irq;
    (irq && !clr_rd && !ext_rst) ##1 (!$rose(s_axi_bvalid_out) && !ext_rst);
  endsequence

  int_float_a: assert property (!int_n_oe_out |-> !int_n_out)
    else $error("Released interrupt line not floating");
  int_hold_a: assert property (held_irq |-> irq)
    else $error("Interrupt released without a clearing event");
  rd_answer_a: assert property (rd_take |=> s_axi_rvalid_out)
    else $error("Read not answered in one cycle");
  rd_unmapped_a: assert property (rd_take ##0 (s_axi_araddr_in > 8'h2B) |=>
    s_axi_rresp_out == `SRI_RESP_SLVERR && s_axi_rdata_out == 32'h0)
    else $error("Unmapped read not refused");
  rd_refuse_a: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
    else $error("Read accepted while answer pending");
  sc_copy_a: assert property (rd_take ##0 (s_axi_araddr_in == `SRI_OFS_RT) |=>
    s_axi_rdata_out == {24'h0, $past(sc_upstream_rt_out)})
    else $error("Upstream copy differs from real-time word");
  chop_half_a: assert property (hi_cnt_r <= 7'd78)
    else $error("Chopper high half too long");
  chan_cmd_a: assert property ($changed(channel_state_flag_out) |->
    $rose(s_axi_bvalid_out) || $past(s_axi_bvalid_out) || ext_rst) // Hard reset lands late
    else $error("Channel state changed without a command");
  pin_reset_a: assert property (!reset_pin_n_in [*3] |=>
    !irq && channel_state_flag_out == '0)
    else $error("Reset pin did not clear interrupt and channels");
endmodule

bind sri_top sri_top_sva #(.NCH(NCH)) chk_u (.*);

// >>> bench/sri_top_tb.sv
// Self-checking bench for the supervision and interrupt block
`timescale 1ns/1ps
`include "sri_defs.svh"
`define CHK(g, e) cmp((g), (e))
module sri_top_tb;
  logic        core_clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
  logic        s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0;
  logic [7:0]  s_axi_awaddr_in = 8'h00, s_axi_araddr_in = 8'h00;
  logic [31:0] s_axi_wdata_in = 32'h0;
  logic [3:0]  s_axi_wstrb_in = 4'hF;
  logic        reset_pin_n_in = 1'b1, chip_select_n_in = 1'b1, serial_data_clock_in = 1'b0;
  logic [3:0]  loop_detect_input_in = 4'h0, second_detect_input_in = 4'h0;
  logic [3:0]  muxed_ground_key_bit_in = 4'h0, tx_pcm_change_in = 4'h0;
  logic        frame_sync_in, irq, s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
  logic        s_axi_arready_out, s_axi_rvalid_out, int_n_out, int_n_oe_out, chopper_clk_out;
  logic [1:0]  s_axi_bresp_out, s_axi_rresp_out, rsp;
  logic [31:0] s_axi_rdata_out, rd_d;
  logic [7:0]  sc_upstream_rt_out;
  logic [3:0]  channel_state_flag_out;
  int          mismatches = 0, checks_done = 0, n;

  sri_top dut_u (.*);
  sri_host_model host_u (.clk_in(core_clk_in), .int_n_in(int_n_out), .int_oe_in(int_n_oe_out),
                         .frame_sync_out(frame_sync_in), .irq_level_out(irq));

  // 40 MHz core clock
  always #12.5 core_clk_in = ~core_clk_in;

  task automatic final_report();
    $display("Checks %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      mismatches++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, g, e);
    end
  endtask

  // A spent wait bound is a failure; stop rather than run on confused
  task automatic tmo();
    cmp(32'h0, 32'h1);
    final_report();
  endtask

  // Handshakes are judged at the falling edge, acted on at the next rising one
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int   k;
    logic ta, tw, tb;
    @(posedge core_clk_in);
    s_axi_awaddr_in  <= a;
    s_axi_wdata_in   <= d;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in  <= 1'b1;
    s_axi_bready_in  <= 1'b1;
    for (k = 0; k < 50; k++)
    begin
      @(negedge core_clk_in);
      ta  = s_axi_awvalid_in && s_axi_awready_out;
      tw  = s_axi_wvalid_in && s_axi_wready_out;
      tb  = s_axi_bvalid_out;
      rsp = s_axi_bresp_out;
      @(posedge core_clk_in);
      if (ta) s_axi_awvalid_in <= 1'b0;
      if (tw) s_axi_wvalid_in <= 1'b0;
      if (tb) break;
    end
    s_axi_bready_in <= 1'b0;
    if (k == 50) tmo();
  endtask

  task automatic rd(input logic [7:0] a);
    int   k;
    logic ta, tb;
    @(posedge core_clk_in);
    s_axi_araddr_in  <= a;
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in  <= 1'b1;
    for (k = 0; k < 50; k++)
    begin
      @(negedge core_clk_in);
      ta   = s_axi_arvalid_in && s_axi_arready_out;
      tb   = s_axi_rvalid_out;
      rd_d = s_axi_rdata_out;
      rsp  = s_axi_rresp_out;
      @(posedge core_clk_in);
      if (ta) s_axi_arvalid_in <= 1'b0;
      if (tb) break;
    end
    s_axi_rready_in <= 1'b0;
    if (k == 50) tmo();
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    cmp(rd_d, e);
  endtask

  task automatic wait_irq();
    int k;
    for (k = 0; k < 400 && !irq; k++) @(negedge core_clk_in);
    if (!irq) tmo();
  endtask

  task automatic pulse(input logic [3:0] v);
    @(posedge core_clk_in);
    tx_pcm_change_in <= v;
    @(posedge core_clk_in);
    tx_pcm_change_in <= 4'h0;
    repeat (4) @(negedge core_clk_in);
  endtask

  // Length of one high half of the chopper, in core cycles
  task automatic meas(output int c);
    int k;
    for (k = 0; k < 400 && !chopper_clk_out; k++) @(negedge core_clk_in);
    for (c = 0; c < 400 && chopper_clk_out; c++) @(negedge core_clk_in);
    if (k == 400 || c == 400) tmo();
  endtask

  // Chip select held low across e rising data-clock edges
  task automatic cs_rst(input int e);
    @(posedge core_clk_in);
    chip_select_n_in <= 1'b0;
    repeat (e)
    begin
      repeat (4) @(posedge core_clk_in);
      serial_data_clock_in <= 1'b1;
      repeat (4) @(posedge core_clk_in);
      serial_data_clock_in <= 1'b0;
    end
    repeat (4) @(posedge core_clk_in);
    chip_select_n_in <= 1'b1;
    repeat (4) @(posedge core_clk_in);
  endtask

  // Main sequence
  initial
  begin
    repeat (3) @(posedge core_clk_in);
    rst_in <= 1'b0;
    rd_chk(`SRI_OFS_MASK, 32'hFF);
    rd_chk(`SRI_OFS_CFG, 32'h0);
    rd_chk(`SRI_OFS_DEB, 32'h8);
    rd_chk(`SRI_OFS_CHEN, 32'hF);
    rd_chk(`SRI_OFS_PCM, 32'h3210);
    rd_chk(`SRI_OFS_STAT, 32'h0);
    `CHK(int_n_oe_out, 1'b0);
    rd(8'h30);
    `CHK(rsp, `SRI_RESP_SLVERR);
    wr(`SRI_OFS_RT, 32'hFF);
    `CHK(rsp, `SRI_RESP_SLVERR);
    $display("Test defaults done");
    // Debounce of zero keeps the filter delay down to a couple of frames
    wr(`SRI_OFS_DEB, 32'h0);
    wr(`SRI_OFS_MASK, 32'h0);
    @(posedge core_clk_in);
    loop_detect_input_in[0] <= 1'b1;
    wait_irq();
    rd_chk(`SRI_OFS_RT, 32'h01);
    `CHK(sc_upstream_rt_out, 8'h01);
    @(posedge core_clk_in);
    loop_detect_input_in[0] <= 1'b0;
    repeat (100) @(negedge core_clk_in);
    `CHK(irq, 1'b1);
    rd_chk(`SRI_OFS_RT, 32'h01);
    rd(`SRI_OFS_RT_CLR);
    rd_chk(`SRI_OFS_STAT, 32'h10);
    rd_chk(`SRI_OFS_RT, 32'h00);
    rd(`SRI_OFS_RT_CLR);
    `CHK(irq, 1'b0);
    $display("Test real-time interrupt done");
    @(posedge core_clk_in);
    second_detect_input_in[1] <= 1'b1;
    muxed_ground_key_bit_in[2] <= 1'b1;
    wait_irq();
    rd_chk(`SRI_OFS_RT, 32'h08);
    wr(`SRI_OFS_MASK, 32'h0);
    `CHK(irq, 1'b0);
    wr(`SRI_OFS_CFG, 32'h8);
    wait_irq();
    repeat (100) @(negedge core_clk_in);
    wr(`SRI_OFS_MASK, 32'h0);
    rd_chk(`SRI_OFS_RT, 32'h20);
    wr(`SRI_OFS_MASK, 32'hFF);
    rd_chk(`SRI_OFS_MASK, 32'hFF);
    @(posedge core_clk_in);
    loop_detect_input_in[2] <= 1'b1;
    repeat (200) @(negedge core_clk_in);
    `CHK(irq, 1'b0);
    rd_chk(`SRI_OFS_RT, 32'h30);
    wr(`SRI_OFS_MASK, 32'h0);
    $display("Test secondary and mask done");
    wr(`SRI_OFS_ATI, 32'h1);
    rd_chk(`SRI_OFS_ATI, 32'h1);
    pulse(4'h2);
    `CHK(irq, 1'b0);
    pulse(4'h1);
    `CHK(irq, 1'b1);
    wr(`SRI_OFS_MASK, 32'h0);
    wr(`SRI_OFS_CFG, 32'h9);
    `CHK({int_n_oe_out, int_n_out}, 2'b11);
    pulse(4'h1);
    `CHK({int_n_oe_out, int_n_out}, 2'b10);
    wr(`SRI_OFS_MASK, 32'h0);
    wr(`SRI_OFS_ATI, 32'h0);
    $display("Test transmit interrupt and output type done");
    `CHK(chopper_clk_out, 1'b0);
    for (int f = 0; f < 2; f++)
    begin
      wr(`SRI_OFS_CFG, 32'hD | (f << 1));
      meas(n);
      meas(n);
      `CHK(n, f ? 68 : 78);
    end
    wr(`SRI_OFS_CFG, 32'h8);
    repeat (3) @(negedge core_clk_in);
    `CHK(chopper_clk_out, 1'b0);
    $display("Test chopper done");
    wr(`SRI_OFS_CMD, 32'h1);
    `CHK(channel_state_flag_out, 4'hF);
    wr(`SRI_OFS_CHEN, 32'h5);
    wr(`SRI_OFS_CMD, 32'h2);
    `CHK(channel_state_flag_out, 4'hA);
    wr(`SRI_OFS_CHEN, 32'hA);
    wr(`SRI_OFS_CMD, 32'h4);
    `CHK(channel_state_flag_out, 4'h0);
    rd_chk(`SRI_OFS_DEB, 32'h0);
    wr(`SRI_OFS_CMD, 32'h1);
    rd_chk(`SRI_OFS_STAT, 32'h0A);
    wr(`SRI_OFS_CMD, 32'h8);
    rd_chk(`SRI_OFS_MASK, 32'hFF);
    `CHK(channel_state_flag_out, 4'h0);
    $display("Test channel state done");
    wr(`SRI_OFS_MASK, 32'h0);
    @(posedge core_clk_in);
    reset_pin_n_in <= 1'b0;
    repeat (5) @(posedge core_clk_in);
    reset_pin_n_in <= 1'b1;
    repeat (4) @(posedge core_clk_in);
    rd_chk(`SRI_OFS_MASK, 32'hFF);
    wr(`SRI_OFS_MASK, 32'h0);
    cs_rst(15);
    rd_chk(`SRI_OFS_MASK, 32'h0);
    cs_rst(16);
    rd_chk(`SRI_OFS_MASK, 32'hFF);
    $display("Test reset sources done");
    // One-tick ground-key period on channel 1; debounce is back at its 8 ms default
    wr(`SRI_OFS_GK, 32'h10);
    second_detect_input_in[1] <= 1'b0;
    repeat (300) @(posedge core_clk_in);
    rd(`SRI_OFS_RT);
    `CHK(rd_d[4:3], 2'b00);
    second_detect_input_in[1] <= 1'b1;
    repeat (560) @(posedge core_clk_in);
    rd(`SRI_OFS_RT);
    `CHK(rd_d[4:3], 2'b00);
    repeat (400) @(posedge core_clk_in);
    rd(`SRI_OFS_RT);
    `CHK(rd_d[4:3], 2'b11);
    $display("Test filters done");
    final_report();
  end
endmodule
